// file: src/sbc_defines.svh
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define SBC_CMD_GET_SCANLINE      8'h45
`define SBC_CMD_WRITE_BRIGHTNESS  8'h51
`define SBC_CMD_READ_BRIGHTNESS   8'h52
`define SBC_CMD_WRITE_CTRL        8'h53
`define SBC_CMD_READ_CTRL         8'h54

// ------------------------------------------------------------
// Control byte fields and reset values
// ------------------------------------------------------------
`define SBC_CTRL_BLOCK_EN_BIT     5
`define SBC_CTRL_DIMMING_EN_BIT   3
`define SBC_CTRL_BACKLIGHT_EN_BIT 2
`define SBC_CTRL_MASK             8'h2C
`define SBC_CTRL_RESET            8'h00
`define SBC_LEVEL_RESET           8'h00
`define SBC_SCANLINE_RESET        16'h0000
`define SBC_DUMMY_BYTE            8'h00

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define SBC_STROBE_LOW_CYC        2'h2

// ------------------------------------------------------------
// Host register map
// ------------------------------------------------------------
`define SBC_REG_CMD_OFS           12'h000
`define SBC_REG_STATUS_OFS        12'h004
`define SBC_REG_RESULT_OFS        12'h008
`define SBC_REG_CFG_OFS           12'h00C
`define SBC_CMD_PARAM_LSB         8
`define SBC_STATUS_BUSY_BIT       0
`define SBC_STATUS_VALID_BIT      1

`endif

// file: src/sbc_device.sv
// Function
// (RQ1) Scanline read: dummy, high byte, low byte.
// (RQ2) Frame length is sync+porches+active lines.
// (RQ3) Scanline zero on first sync line.
// (RQ4) Host ignores scanline read during sleep.
// (RQ5) Brightness write stores one 8-bit parameter.
// (RQ6) Brightness code monotonic, 00h lowest.
// (RQ7) Brightness read: dummy then value.
// (RQ8) Sleep-in clears stored brightness.
// (RQ9) Block disabled: brightness reads zero.
// (RQ10) Block enabled: reads manual brightness.
// (RQ11) Control byte bits 5, 3, 2.
// (RQ12) Block disabled forces effective brightness zero.
// (RQ13) Dimming enable gates gradual manual changes.
// (RQ14) Backlight clear drives control lines low.
// (RQ15) Block toggle with dimming ramps gradually.
// (RQ16) Backlight off is immediate, no ramp.
// (RQ17) Control read: dummy then control byte.
// (RQ18) Ramp steps one code per interval.
`include "sbc_defines.svh"

module sbc_device
  import sbc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  sbc_if.device            link,
  input  wire logic        sleep_in,
  input  wire logic        line_tick,
  input  wire logic [15:0] vert_sync_lines,
  input  wire logic [15:0] vert_back_porch_lines,
  input  wire logic [15:0] vert_active_lines,
  input  wire logic [15:0] vert_front_porch_lines,
  input  wire logic [15:0] dim_step_cycles,
  output logic      [15:0] scanline_reg,
  output logic      [7:0]  brightness_level_reg,
  output logic      [7:0]  brightness_ctrl_reg,
  output logic      [7:0]  effective_brightness,
  output logic             dimming_active,
  output logic             backlight_ctl_reg
);
  sbc_dev_state_t state_reg;
  logic           wr_prev_reg;
  logic           rd_prev_reg;
  logic [1:0]     rd_idx_reg;
  sbc_byte_t      rd_bytes_reg [0:2];
  logic [7:0]     dev_out_reg;
  logic           dev_oe_n_reg;
  logic           wr_rise;
  logic           rd_rise;
  logic [15:0]    frame_lines;
  logic           block_en;
  logic           dimming_en;
  logic           backlight_en;
  logic [7:0]     reported_level;
  logic [7:0]     dim_target;

  assign link.dev_db_out  = dev_out_reg;
  assign link.dev_db_oe_n = dev_oe_n_reg;

  assign wr_rise = link.write_strobe_n & ~wr_prev_reg;
  assign rd_rise = link.read_strobe_n & ~rd_prev_reg;

  assign block_en     = brightness_ctrl_reg[`SBC_CTRL_BLOCK_EN_BIT];
  assign dimming_en   = brightness_ctrl_reg[`SBC_CTRL_DIMMING_EN_BIT];
  assign backlight_en = brightness_ctrl_reg[`SBC_CTRL_BACKLIGHT_EN_BIT];

  // ------------------------------------------------------------
  // Frame length and reported brightness.
  // ------------------------------------------------------------
  assign frame_lines = vert_sync_lines + vert_back_porch_lines
                     + vert_active_lines + vert_front_porch_lines; // RQ2

  assign reported_level = block_en ? brightness_level_reg : 8'h00; // RQ9 RQ10
  assign dim_target     = block_en ? brightness_level_reg : 8'h00; // RQ12 RQ6

  // ------------------------------------------------------------
  // Strobe edge history.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
    end else if (ce) begin
      wr_prev_reg <= link.write_strobe_n;
      rd_prev_reg <= link.read_strobe_n;
    end
  end

  // ------------------------------------------------------------
  // Scanline counter.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scanline_reg <= `SBC_SCANLINE_RESET;
    end else if (ce && line_tick) begin
      if (scanline_reg + 16'h0001 >= frame_lines) begin
        scanline_reg <= 16'h0000; // RQ3
      end else begin
        scanline_reg <= scanline_reg + 16'h0001; // RQ3
      end
    end
  end

  // ------------------------------------------------------------
  // Command decode and parameter writes.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SBC_DS_IDLE;
    end else if (ce && wr_rise) begin
      if (!link.cmd_param_select) begin
        case (link.db)
          `SBC_CMD_WRITE_BRIGHTNESS: state_reg <= SBC_DS_WR_BV;
          `SBC_CMD_WRITE_CTRL:       state_reg <= SBC_DS_WR_CTRL;
          `SBC_CMD_GET_SCANLINE,
          `SBC_CMD_READ_BRIGHTNESS,
          `SBC_CMD_READ_CTRL:        state_reg <= SBC_DS_RD;
          default:                   state_reg <= SBC_DS_IDLE;
        endcase
      end else begin
        case (state_reg)
          SBC_DS_WR_BV:   state_reg <= SBC_DS_IDLE;
          SBC_DS_WR_CTRL: state_reg <= SBC_DS_IDLE;
          default:        state_reg <= state_reg;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brightness_level_reg <= `SBC_LEVEL_RESET;
    end else if (ce) begin
      if (sleep_in) begin
        brightness_level_reg <= 8'h00; // RQ8
      end else if (wr_rise && link.cmd_param_select && state_reg == SBC_DS_WR_BV) begin
        brightness_level_reg <= link.db; // RQ5
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brightness_ctrl_reg <= `SBC_CTRL_RESET;
    end else if (ce && wr_rise && link.cmd_param_select && state_reg == SBC_DS_WR_CTRL) begin
      brightness_ctrl_reg <= link.db & `SBC_CTRL_MASK; // RQ11
    end
  end

  // ------------------------------------------------------------
  // Read parameter sequence, snapshot taken at the command.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_idx_reg      <= 2'h0;
      rd_bytes_reg[0] <= `SBC_DUMMY_BYTE;
      rd_bytes_reg[1] <= 8'h00;
      rd_bytes_reg[2] <= 8'h00;
    end else if (ce) begin
      if (wr_rise && !link.cmd_param_select) begin
        rd_idx_reg      <= 2'h0;
        rd_bytes_reg[0] <= `SBC_DUMMY_BYTE; // RQ1 RQ7 RQ17
        case (link.db)
          `SBC_CMD_GET_SCANLINE: begin
            rd_bytes_reg[1] <= scanline_reg[15:8]; // RQ1
            rd_bytes_reg[2] <= scanline_reg[7:0]; // RQ1
          end
          `SBC_CMD_READ_BRIGHTNESS: begin
            rd_bytes_reg[1] <= reported_level; // RQ7
            rd_bytes_reg[2] <= 8'h00;
          end
          `SBC_CMD_READ_CTRL: begin
            rd_bytes_reg[1] <= brightness_ctrl_reg; // RQ17
            rd_bytes_reg[2] <= 8'h00;
          end
          default: begin
            rd_bytes_reg[1] <= 8'h00;
            rd_bytes_reg[2] <= 8'h00;
          end
        endcase
      end else if (rd_rise && state_reg == SBC_DS_RD && rd_idx_reg != 2'h3) begin
        rd_idx_reg <= rd_idx_reg + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Data bus drive, registered one cycle behind the read strobe.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dev_oe_n_reg <= 1'b1;
      dev_out_reg  <= 8'h00;
    end else if (ce) begin
      dev_oe_n_reg <= link.read_strobe_n;
      if (state_reg == SBC_DS_RD && rd_idx_reg != 2'h3) begin
        dev_out_reg <= rd_bytes_reg[rd_idx_reg];
      end else begin
        dev_out_reg <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // Backlight and effective brightness.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      backlight_ctl_reg <= 1'b0;
    end else if (ce) begin
      backlight_ctl_reg <= backlight_en; // RQ14
    end
  end

  sbc_dimmer u_dimmer (
    .clk         (clk),
    .rstn        (rstn),
    .ce          (ce),
    .target      (dim_target),
    .ramp_en     (dimming_en), // RQ13
    .force_zero  (~backlight_en), // RQ16 RQ14
    .step_cycles (dim_step_cycles),
    .level_reg   (effective_brightness),
    .ramping_reg (dimming_active)
  );
endmodule : sbc_device

// file: src/sbc_dimmer.sv
`include "sbc_defines.svh"

module sbc_dimmer
  import sbc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [7:0]  target,
  input  wire logic        ramp_en,
  input  wire logic        force_zero,
  input  wire logic [15:0] step_cycles,
  output logic      [7:0]  level_reg,
  output logic             ramping_reg
);
  logic [15:0] cnt_reg;
  logic        at_target;

  assign at_target = (level_reg == target);

  // ------------------------------------------------------------
  // Effective level: jump, force or ramp one code per interval.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_reg   <= `SBC_LEVEL_RESET;
      cnt_reg     <= 16'h0000;
      ramping_reg <= 1'b0;
    end else if (ce) begin
      if (force_zero) begin
        level_reg   <= 8'h00; // RQ16
        cnt_reg     <= 16'h0000;
        ramping_reg <= 1'b0;
      end else if (!ramp_en || at_target) begin
        level_reg   <= target;
        cnt_reg     <= 16'h0000;
        ramping_reg <= 1'b0;
      end else begin
        ramping_reg <= 1'b1;
        if (cnt_reg + 16'h0001 >= step_cycles) begin // RQ18
          cnt_reg   <= 16'h0000;
          level_reg <= (level_reg < target) ? level_reg + 8'h01 : level_reg - 8'h01; // RQ15
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end
endmodule : sbc_dimmer

// file: src/sbc_host.sv
`include "sbc_defines.svh"

module sbc_host
  import sbc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  sbc_if.host              link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  sbc_host_state_t state_reg;
  logic [7:0]      cmd_reg;
  logic [7:0]      param_reg;
  logic [1:0]      left_reg;
  logic [1:0]      phase_reg;
  logic [1:0]      hold_reg;
  logic [15:0]     result_reg;
  logic            asleep_reg;
  logic            valid_reg;
  logic            busy;
  logic            go;
  logic            wr_cmd;
  logic            wr_cfg;
  logic            mapped;

  // ------------------------------------------------------------
  // Parameter counts per command.
  // ------------------------------------------------------------
  function automatic logic [1:0] sbc_read_count(input logic [7:0] code);
    case (code)
      `SBC_CMD_GET_SCANLINE:    sbc_read_count = 2'h3;
      `SBC_CMD_READ_BRIGHTNESS,
      `SBC_CMD_READ_CTRL:       sbc_read_count = 2'h2;
      default:                  sbc_read_count = 2'h0;
    endcase
  endfunction : sbc_read_count

  function automatic logic [1:0] sbc_write_count(input logic [7:0] code);
    case (code)
      `SBC_CMD_WRITE_BRIGHTNESS,
      `SBC_CMD_WRITE_CTRL:      sbc_write_count = 2'h1;
      default:                  sbc_write_count = 2'h0;
    endcase
  endfunction : sbc_write_count

  assign busy   = (state_reg != SBC_HS_IDLE);
  assign mapped = (paddr == `SBC_REG_CMD_OFS) || (paddr == `SBC_REG_STATUS_OFS)
               || (paddr == `SBC_REG_RESULT_OFS) || (paddr == `SBC_REG_CFG_OFS);
  assign wr_cmd = psel & penable & pready & pwrite & (paddr == `SBC_REG_CMD_OFS);
  assign wr_cfg = psel & penable & pready & pwrite & (paddr == `SBC_REG_CFG_OFS);
  assign go     = wr_cmd & ~busy;

  // ------------------------------------------------------------
  // APB slave, no wait states.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SBC_REG_STATUS_OFS: prdata <= {30'h00000000, valid_reg, busy};
          `SBC_REG_RESULT_OFS: prdata <= {16'h0000, result_reg};
          `SBC_REG_CFG_OFS:    prdata <= {31'h00000000, asleep_reg};
          default:             prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      asleep_reg <= 1'b0;
    end else if (ce && wr_cfg) begin
      asleep_reg <= pwdata[0];
    end
  end

  // ------------------------------------------------------------
  // Link sequencer.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg              <= SBC_HS_IDLE;
      cmd_reg                <= 8'h00;
      param_reg              <= 8'h00;
      left_reg               <= 2'h0;
      phase_reg              <= 2'h0;
      hold_reg               <= 2'h0;
      result_reg             <= 16'h0000;
      valid_reg              <= 1'b0;
      link.cmd_param_select  <= 1'b1;
      link.write_strobe_n    <= 1'b1;
      link.read_strobe_n     <= 1'b1;
      link.host_db_out       <= 8'h00;
      link.host_db_oe_n      <= 1'b1;
    end else if (ce) begin
      case (state_reg)
        SBC_HS_IDLE: begin
          if (go) begin
            cmd_reg               <= pwdata[7:0];
            param_reg             <= pwdata[`SBC_CMD_PARAM_LSB +: 8];
            phase_reg             <= 2'h0;
            result_reg            <= 16'h0000;
            valid_reg             <= 1'b0;
            link.cmd_param_select <= 1'b0;
            link.host_db_out      <= pwdata[7:0];
            link.host_db_oe_n     <= 1'b0;
            link.write_strobe_n   <= 1'b0;
            state_reg             <= SBC_HS_WR_LO;
          end
        end
        SBC_HS_WR_LO: begin
          link.write_strobe_n <= 1'b1;
          state_reg           <= SBC_HS_WR_HI;
        end
        SBC_HS_WR_HI: begin
          if (phase_reg == 2'h0 && sbc_write_count(cmd_reg) != 2'h0) begin
            phase_reg             <= 2'h1;
            link.cmd_param_select <= 1'b1;
            link.host_db_out      <= (cmd_reg == `SBC_CMD_WRITE_CTRL)
                                   ? (param_reg & `SBC_CTRL_MASK) : param_reg; // RQ5 RQ11
            link.write_strobe_n   <= 1'b0;
            state_reg             <= SBC_HS_WR_LO;
          end else if (phase_reg == 2'h0 && sbc_read_count(cmd_reg) != 2'h0) begin
            left_reg              <= sbc_read_count(cmd_reg);
            hold_reg              <= 2'h0;
            link.cmd_param_select <= 1'b1;
            link.host_db_oe_n     <= 1'b1;
            link.read_strobe_n    <= 1'b0;
            state_reg             <= SBC_HS_RD_LO;
          end else begin
            link.cmd_param_select <= 1'b1;
            link.host_db_oe_n     <= 1'b1;
            link.host_db_out      <= 8'h00;
            state_reg             <= SBC_HS_IDLE;
          end
        end
        SBC_HS_RD_LO: begin
          if (hold_reg + 2'h1 >= `SBC_STROBE_LOW_CYC) begin
            if (left_reg != sbc_read_count(cmd_reg)) begin
              result_reg <= {result_reg[7:0], link.db}; // RQ1 RQ7 RQ17
            end
            left_reg           <= left_reg - 2'h1;
            link.read_strobe_n <= 1'b1;
            state_reg          <= SBC_HS_RD_HI;
          end else begin
            hold_reg <= hold_reg + 2'h1;
          end
        end
        SBC_HS_RD_HI: begin
          hold_reg <= 2'h0;
          if (left_reg != 2'h0) begin
            link.read_strobe_n <= 1'b0;
            state_reg          <= SBC_HS_RD_LO;
          end else begin
            valid_reg <= ~(asleep_reg && cmd_reg == `SBC_CMD_GET_SCANLINE); // RQ4
            state_reg <= SBC_HS_IDLE;
          end
        end
        default: state_reg <= SBC_HS_IDLE;
      endcase
    end
  end
endmodule : sbc_host

// file: src/sbc_if.sv
interface sbc_if;
  logic       cmd_param_select;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic [7:0] host_db_out;
  logic       host_db_oe_n;
  logic [7:0] dev_db_out;
  logic       dev_db_oe_n;
  logic [7:0] db;

  // ------------------------------------------------------------
  // Data bus level resolved from the two enables.
  // ------------------------------------------------------------
  assign db = !host_db_oe_n ? host_db_out : (!dev_db_oe_n ? dev_db_out : 8'h00);

  modport host (
    output cmd_param_select, write_strobe_n, read_strobe_n, host_db_out, host_db_oe_n,
    input  db
  );
  modport device (
    input  cmd_param_select, write_strobe_n, read_strobe_n, db,
    output dev_db_out, dev_db_oe_n
  );
endinterface : sbc_if

// file: src/sbc_pkg.sv
package sbc_pkg;

  typedef enum logic [3:0] {
    SBC_DS_IDLE    = 4'h1,
    SBC_DS_WR_BV   = 4'h2,
    SBC_DS_WR_CTRL = 4'h4,
    SBC_DS_RD      = 4'h8
  } sbc_dev_state_t;

  typedef enum logic [4:0] {
    SBC_HS_IDLE   = 5'h01,
    SBC_HS_WR_LO  = 5'h02,
    SBC_HS_WR_HI  = 5'h04,
    SBC_HS_RD_LO  = 5'h08,
    SBC_HS_RD_HI  = 5'h10
  } sbc_host_state_t;

  typedef logic [7:0] sbc_byte_t;

endpackage : sbc_pkg

// file: tb/sbc_link_checker.sv
module sbc_link_checker (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       cmd_param_select,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] host_db_out,
  input wire logic       host_db_oe_n,
  input wire logic [7:0] dev_db_out,
  input wire logic       dev_db_oe_n,
  input wire logic [7:0] db
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Link handshake properties.
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_wr_pulse;
    $fell(write_strobe_n) |=> write_strobe_n;
  endproperty
  property p_rd_pulse;
    $fell(read_strobe_n) |=> !read_strobe_n ##1 read_strobe_n;
  endproperty
  property p_dev_answer;
    $fell(read_strobe_n) |=> !dev_db_oe_n [*2] ##1 dev_db_oe_n;
  endproperty
  property p_dev_release;
    read_strobe_n ##1 read_strobe_n |-> dev_db_oe_n;
  endproperty
  property p_no_clash;
    !(!host_db_oe_n && !dev_db_oe_n);
  endproperty
  property p_wr_owned;
    !write_strobe_n |-> !host_db_oe_n;
  endproperty
  property p_wr_hold;
    !write_strobe_n |=> $stable(host_db_out) && $stable(cmd_param_select);
  endproperty
  property p_strobe_excl;
    !(!write_strobe_n && !read_strobe_n);
  endproperty
  property p_rd_param;
    !read_strobe_n |-> host_db_oe_n && cmd_param_select;
  endproperty

  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe not one cycle");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe not two cycles");
  a_dev_answer: assert property (p_dev_answer) else $error("device answer late");
  a_dev_release: assert property (p_dev_release) else $error("device holds bus");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive bus");
  a_wr_owned: assert property (p_wr_owned) else $error("write without data");
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
  a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");
  a_rd_param: assert property (p_rd_param) else $error("read not a parameter");

  c_cmd_byte: cover property ($fell(write_strobe_n) && !cmd_param_select);
  c_param_byte: cover property ($fell(write_strobe_n) && cmd_param_select);
  c_read_byte: cover property ($fell(read_strobe_n));
endmodule : sbc_link_checker

// file: tb/test_scanline_brightness_cmds.sv
`include "sbc_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0t: got %0h expected %0h", $time, g, e); end end

module test_scanline_brightness_cmds;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rstn;
  logic        ce;
  logic        sleep_in;
  logic        line_tick;
  logic [15:0] dim_step;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] scanline_reg;
  logic [7:0]  level_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  eff;
  logic        dim_act;
  logic        bl_q;
  logic [31:0] rd_word;
  logic        rd_err;
  logic [7:0]  vals [6];
  int          err_total;
  int          compares;
  int          cyc;
  int          d;

  sbc_if link_if ();

  sbc_host u_sbc_host (.clk(clk), .rstn(rstn), .ce(ce), .link(link_if), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  sbc_device u_sbc_device (.clk(clk), .rstn(rstn), .ce(ce), .link(link_if),
    .sleep_in(sleep_in), .line_tick(line_tick), .vert_sync_lines(16'h0002),
    .vert_back_porch_lines(16'h0003), .vert_active_lines(16'h0120),
    .vert_front_porch_lines(16'h0005), .dim_step_cycles(dim_step),
    .scanline_reg(scanline_reg), .brightness_level_reg(level_q),
    .brightness_ctrl_reg(ctrl_q), .effective_brightness(eff),
    .dimming_active(dim_act), .backlight_ctl_reg(bl_q));

  sbc_link_checker u_sbc_link_checker (.clk(clk), .rstn(rstn),
    .cmd_param_select(link_if.cmd_param_select), .write_strobe_n(link_if.write_strobe_n),
    .read_strobe_n(link_if.read_strobe_n), .host_db_out(link_if.host_db_out),
    .host_db_oe_n(link_if.host_db_oe_n), .dev_db_out(link_if.dev_db_out),
    .dev_db_oe_n(link_if.dev_db_oe_n), .db(link_if.db));

  // ------------------------------------------------------------
  // Bus and command tasks.
  // ------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_word = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task cmd(input logic [7:0] c, input logic [7:0] p);
    apb(1'b1, `SBC_REG_CMD_OFS, {16'h0000, p, c});
    do begin
      apb(1'b0, `SBC_REG_STATUS_OFS, 32'h0);
    end while (rd_word[0] !== 1'b0);
  endtask : cmd

  task rdc(input logic [7:0] c);
    cmd(c, 8'h00);
    apb(1'b0, `SBC_REG_RESULT_OFS, 32'h0);
  endtask : rdc

  task tick(input int n);
    repeat (n) begin
      @(posedge clk);
      line_tick <= 1'b1;
      @(posedge clk);
      line_tick <= 1'b0;
    end
  endtask : tick

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task t_regs;
    apb(1'b0, `SBC_REG_RESULT_OFS, 32'h0);
    `CHK(rd_word, 32'h0000_0000)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({rd_err, rd_word}, 33'h1_0000_0000)
  endtask : t_regs

  task t_scan;
    rdc(8'h45);
    `CHK(rd_word[15:0], 16'h0000)
    tick(261);
    rdc(8'h45);
    `CHK(rd_word[15:0], 16'h0105)
    tick(37);
    rdc(8'h45);
    `CHK(rd_word[15:0], 16'h0000)
    tick(5);
    @(posedge clk);
    `CHK(scanline_reg, 16'h0005)
    ce <= 1'b0;
    tick(3);
    ce <= 1'b1;
    @(posedge clk);
    `CHK(scanline_reg, 16'h0005)
  endtask : t_scan

  task t_bright;
    for (int i = 0; i < 3; i++) begin
      cmd(8'h53, 8'h00);
      cmd(8'h51, vals[i]);
      rdc(8'h52);
      `CHK(rd_word[7:0], 8'h00)
      `CHK(eff, 8'h00)
      cmd(8'h53, 8'h24);
      rdc(8'h52);
      `CHK(rd_word[7:0], vals[i])
      `CHK(level_q, vals[i])
      `CHK(eff, vals[i])
    end
  endtask : t_bright

  task t_ctrl;
    for (int i = 0; i < 6; i++) begin
      cmd(8'h53, vals[i]);
      rdc(8'h54);
      `CHK(rd_word[7:0], vals[i] & `SBC_CTRL_MASK)
      `CHK(ctrl_q, vals[i] & `SBC_CTRL_MASK)
      `CHK(bl_q, vals[i][2])
    end
  endtask : t_ctrl

  task t_dim;
    cmd(8'h53, 8'h24);
    cmd(8'h51, 8'h40);
    `CHK(eff, 8'h40)
    cmd(8'h53, 8'h2C);
    cmd(8'h53, 8'h0C);
    `CHK(dim_act, 1'b1)
    d = eff;
    repeat (20) @(posedge clk);
    d = d - eff;
    `CHK(d >= 9 && d <= 11, 1'b1)
    repeat (200) @(posedge clk);
    `CHK(eff, 8'h00)
    cmd(8'h53, 8'h2C);
    repeat (150) @(posedge clk);
    `CHK(eff, 8'h40)
    cmd(8'h53, 8'h28);
    `CHK({bl_q, eff}, 9'h000)
  endtask : t_dim

  task t_sleep;
    apb(1'b1, `SBC_REG_CFG_OFS, 32'h1);
    cmd(8'h45, 8'h00);
    `CHK(rd_word[1], 1'b0)
    apb(1'b1, `SBC_REG_CFG_OFS, 32'h0);
    cmd(8'h45, 8'h00);
    `CHK(rd_word[1], 1'b1)
    cmd(8'h53, 8'h24);
    cmd(8'h51, 8'h77);
    @(posedge clk);
    sleep_in <= 1'b1;
    repeat (3) @(posedge clk);
    sleep_in <= 1'b0;
    rdc(8'h52);
    `CHK({level_q, rd_word[7:0]}, 16'h0000)
  endtask : t_sleep

  task close_out;
    $display("Checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      close_out;
    end
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    sleep_in = 1'b0;
    line_tick = 1'b0;
    dim_step = 16'h0002;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    vals = '{8'h00, 8'hFF, 8'hA5, 8'h08, 8'h2C, 8'h20};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_scan;
    t_bright;
    t_ctrl;
    t_dim;
    t_sleep;
    close_out;
  end
endmodule : test_scanline_brightness_cmds
